// file: hdl/sar_adc_conversion_sequencer.sv
// Purpose: Conversion sequencing, result coding and serial readout of a 14-bit SAR converter.
// Assumes: Start and serial clock inputs are asynchronous to clock; the comparator answers per trial level.
// Notes:   Serial clock is sampled, not used as a clock.
// Behaviour
// - A falling start edge puts the sampler into hold and starts the search once the device is awake.
// - A conversion finishes within 5 us normally and within 10 us after sleep.
// - The result is 14 bits found by successive approximation.
// - Bipolar variants encode in twos complement with midscale at the ones/zeros boundary.
// - The unipolar variant encodes straight binary with zero at ground.
// - Two modes exist; in auto-sleep the device sleeps once a conversion ends.
// - Conversion steps are timed by an internal conversion clock, not the serial clock.
// - Sixteen bits shift out on falling serial edges, two zeros then the result, then release.
// - Busy rises on the start falling edge and falls when conversion completes.
// - Start low at conversion end gives power-down; a later rising edge starts wake-up.
// - Every start falling edge resets the output shift register.
`timescale 1ns/1ps
module sar_adc_conversion_sequencer
    import sar_seq_pkg::*;
#(
    parameter range_t RANGE = RANGE_BIPOLAR
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        conversion_start_n,
    input  wire logic        serial_clock,
    input  wire logic        comparator_high,
    output logic [13:0]      trial_level,
    output logic             sampler_hold,
    output logic             busy,
    output logic             asleep,
    output logic             serial_result_out,
    output logic             serial_result_oe_n
);
    typedef enum logic [1:0] {IDLE, WAKING, CONVERT} state_t;
    state_t state;

    logic [1:0]  startSync;
    logic [1:0]  sclkSync;
    logic        startPrev;
    logic        sclkPrev;
    logic [4:0]  bitIndex;
    logic [15:0] stepCount;
    logic [13:0] approx;
    logic [15:0] shifter;
    logic [4:0]  shiftCount;
    logic [1:0]  holdCount;
    logic        releasing;
    serial_pin_t pin;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            startSync <= 2'h3;
            sclkSync  <= 2'h0;
            startPrev <= 1'b1;
            sclkPrev  <= 1'b0;
        end else begin
            startSync <= {startSync[0], conversion_start_n};
            sclkSync  <= {sclkSync[0], serial_clock};
            startPrev <= startSync[1];
            sclkPrev  <= sclkSync[1];
        end
    end

    wire startFall = startPrev & ~startSync[1];
    wire startRise = ~startPrev & startSync[1];
    wire sclkFall  = sclkPrev & ~sclkSync[1];
    // Conversion clock tick, internal and free of the serial clock
    // internal step timing
    wire stepTick  = (stepCount == 16'(STEP_CYC - 1));
    // fifteen ticks bound the conversion time
    wire lastStep  = (bitIndex == 5'(RESULT_BITS));
    wire convDone  = (state == CONVERT) && stepTick && lastStep;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state        <= IDLE;
            busy         <= 1'b0;
            sampler_hold <= 1'b0;
            asleep       <= 1'b0;
            stepCount    <= 16'h0000;
            bitIndex     <= 5'h00;
        end else begin
            unique case (state)
                IDLE: begin
                    if (asleep && startRise) begin
                        state     <= WAKING;
                        stepCount <= 16'h0000;
                    end else if (startFall && !asleep) begin
                        state        <= CONVERT;
                        busy         <= 1'b1;
                        sampler_hold <= 1'b1;
                        stepCount    <= 16'h0000;
                        bitIndex     <= 5'h00;
                    end
                end
                WAKING: begin
                    // busy rises with the start edge
                    if (startFall) begin
                        busy <= 1'b1;
                    end
                    if (stepCount == 16'(WAKE_CYC - 1)) begin
                        // wake finished; hold only once a start fall was seen
                        asleep    <= 1'b0;
                        stepCount <= 16'h0000;
                        bitIndex  <= 5'h00;
                        if (busy || startFall) begin
                            state        <= CONVERT;
                            busy         <= 1'b1;
                            sampler_hold <= 1'b1;
                        end else begin
                            state <= IDLE;
                        end
                    end else begin
                        stepCount <= stepCount + 16'h0001;
                    end
                end
                CONVERT: begin
                    stepCount <= stepTick ? 16'h0000 : stepCount + 16'h0001;
                    if (stepTick) begin
                        bitIndex <= bitIndex + 5'h01;
                    end
                    if (convDone) begin
                        state        <= IDLE;
                        busy         <= 1'b0;
                        sampler_hold <= 1'b0;
                        asleep       <= ~startSync[1];
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    // binary search, one bit per tick
    always_ff @(posedge clock) begin
        if (!resetn) begin
            approx <= 14'h0000;
        end else if (state == CONVERT && stepTick && !lastStep) begin
            approx[13 - bitIndex[3:0]] <= comparator_high;
            if (bitIndex < 5'(RESULT_BITS - 1)) begin
                approx[12 - bitIndex[3:0]] <= 1'b1;
            end
        end else if (state != CONVERT) begin
            approx <= 14'h2000;
        end
    end
    assign trial_level = approx;

    wire [13:0] coded = (RANGE == RANGE_BIPOLAR) ? {~approx[13], approx[12:0]} : approx;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            shifter    <= 16'h0000;
            shiftCount <= 5'h00;
            holdCount  <= 2'h0;
            releasing  <= 1'b0;
            pin        <= '{data: 1'b0, enableN: 1'b1};
        end else if (startFall) begin
            shiftCount <= 5'h00;
            releasing  <= 1'b0;
            pin        <= '{data: 1'b0, enableN: 1'b1};
        end else if (convDone) begin
            shifter    <= {{LEAD_ZEROS{1'b0}}, coded};
            shiftCount <= 5'h00;
        end else if (sclkFall) begin
            shifter    <= {shifter[14:0], 1'b0};
            // Count stops at the frame length so extra clocks never re-drive the pin
            if (shiftCount != 5'(FRAME_BITS)) begin
                shiftCount <= shiftCount + 5'h01;
            end
            pin.data   <= shifter[15];
            if (shiftCount == 5'(FRAME_BITS - 1)) begin
                releasing <= 1'b1;
                holdCount <= 2'h0;
            end else if (shiftCount < 5'(FRAME_BITS - 1)) begin
                pin.enableN <= 1'b0;
            end
        end else if (releasing) begin
            if (holdCount == 2'(HOLD_CYC - 1)) begin
                releasing   <= 1'b0;
                pin.enableN <= 1'b1;
            end else begin
                holdCount <= holdCount + 2'h1;
            end
        end
    end
    assign serial_result_out  = pin.data;
    assign serial_result_oe_n = pin.enableN;

    // Helper count of conversion length
    logic [15:0] convCycles;
    always_ff @(posedge clock) begin
        if (!resetn || state != CONVERT) begin
            convCycles <= 16'h0000;
        end else begin
            convCycles <= convCycles + 16'h0001;
        end
    end

    conv_bound_a: assert property (@(posedge clock) disable iff (!resetn)
        convCycles <= 16'(CONV_FAST_CYC))
        else $error("conversion overran its time");

    busy_rise_a: assert property (@(posedge clock) disable iff (!resetn)
        (state == IDLE && !asleep && startFall) |=> busy && sampler_hold)
        else $error("busy did not rise on start");

    busy_fall_a: assert property (@(posedge clock) disable iff (!resetn)
        convDone |=> !busy && !sampler_hold)
        else $error("busy did not fall at completion");

    sleep_entry_a: assert property (@(posedge clock) disable iff (!resetn)
        (convDone && !startSync[1]) |=> asleep)
        else $error("no power-down with start low");

    sequence wakeStart;
        state == IDLE && asleep && startRise;
    endsequence
    wake_path_a: assert property (@(posedge clock) disable iff (!resetn)
        wakeStart |=> state == WAKING [*8])
        else $error("wake-up not begun");

    shift_reset_a: assert property (@(posedge clock) disable iff (!resetn)
        startFall |=> shiftCount == 5'h00 && serial_result_oe_n)
        else $error("shift register not reset");

    lead_zero_a: assert property (@(posedge clock) disable iff (!resetn)
        (sclkFall && shiftCount < 5'(LEAD_ZEROS) && !startFall && !convDone)
        |=> !serial_result_out)
        else $error("leading bit not zero");

    release_a: assert property (@(posedge clock) disable iff (!resetn)
        (sclkFall && shiftCount == 5'(FRAME_BITS - 1) && !startFall && !convDone)
        |=> !serial_result_oe_n ##[1:3] serial_result_oe_n)
        else $error("data line not released");

    wake_idle_a: assert property (@(posedge clock) disable iff (!resetn)
        (state == WAKING && stepCount == 16'(WAKE_CYC - 1) && !busy && !startFall)
        |=> state == IDLE && !busy && !sampler_hold && !asleep)
        else $error("conversion began without a start edge");
endmodule : sar_adc_conversion_sequencer

// file: hdl/sar_seq_pkg.sv
// Purpose: Shared constants and types for the conversion sequencer.
// Assumes: 200 MHz system clock.
// Notes:   Times are kept in ns; cycle counts derive from them.
package sar_seq_pkg;
    localparam int CLOCK_PERIOD_NS   = 5;
    localparam int RESULT_BITS       = 14;
    localparam int FRAME_BITS        = 16;
    localparam int LEAD_ZEROS        = FRAME_BITS - RESULT_BITS;
    localparam int CODE_STEPS        = 16384;
    localparam int CONV_FAST_NS      = 5000;
    localparam int CONV_SLEEP_NS     = 10000;
    localparam int WAKE_NS           = 5000;
    localparam int HOLD_TIME_NS      = 10;
    localparam int CONV_FAST_CYC     = CONV_FAST_NS / CLOCK_PERIOD_NS;
    localparam int CONV_SLEEP_CYC    = CONV_SLEEP_NS / CLOCK_PERIOD_NS;
    localparam int WAKE_CYC          = WAKE_NS / CLOCK_PERIOD_NS;
    localparam int HOLD_CYC          = (HOLD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    // Conversion clock ticks spread evenly over the fast conversion time
    localparam int STEP_CYC          = CONV_FAST_CYC / (RESULT_BITS + 1);

    typedef enum logic [1:0] {
        RANGE_BIPOLAR,
        RANGE_UNIPOLAR
    } range_t;

    typedef struct packed {
        logic data;
        logic enableN;
    } serial_pin_t;
endpackage : sar_seq_pkg

// file: verif/host_model.sv
// Purpose: Host side of the converter: analog comparator stand-in and serial reader.
// Assumes: serial clock period 80 ns, idle low between frames.
// Notes:   A bit seen while the pin is released is recorded as unknown.
`timescale 1ns/1ps
module host_model
    import sar_seq_pkg::*;
(
    input  wire logic        busy,
    input  wire logic [13:0] analogCode,
    input  wire logic [13:0] trial_level,
    input  wire logic        serial_result_out,
    input  wire logic        serial_result_oe_n,
    output logic             comparator_high,
    output logic             serial_clock,
    output logic [15:0]      frame
);
    // Input at or above the trial level keeps the bit
    assign comparator_high = (analogCode >= trial_level);
    initial serial_clock = 1'b0;
    // no read while converting
    // A cut frame clocks only the first bits and leaves the clock low
    task automatic read_frame(input int bits);
        frame = 'x;
        #1;
        if (busy === 1'b0) begin
            for (int i = 15; i > 15 - bits; i--) begin
                serial_clock = 1'b1;
                #40 serial_clock = 1'b0;
                #19 frame[i] = serial_result_oe_n ? 1'bx : serial_result_out;
                #21;
            end
        end
    endtask : read_frame
endmodule : host_model

// file: verif/test_sar_adc_conversion_sequencer.sv
// Purpose: Self-checking bench for both coding variants of the sequencer.
// Assumes: 200 MHz clock, inputs driven on falling clock edges.
// Notes:   Both variants share the start pin and analog value.
`timescale 1ns/1ps
module test_sar_adc_conversion_sequencer;
    import sar_seq_pkg::*;
    typedef struct packed { logic [13:0] analog; logic [13:0] bip; logic [13:0] uni; } row_t;
    logic        clock, resetn, startN;
    logic [13:0] analogCode, trialB, trialU;
    logic        compB, compU, sclkB, sclkU, holdB, holdU, busyB, busyU;
    logic        sleepB, sleepU, dataB, dataU, oeB, oeU;
    logic [15:0] frameB, frameU;
    int          bad_count = 0;
    int          compares = 0;
    int          n1, n2;
    row_t        rows [5] = '{'{14'h0000, 14'h2000, 14'h0000}, '{14'h2000, 14'h0000, 14'h2000},
        '{14'h1fff, 14'h3fff, 14'h1fff}, '{14'h3fff, 14'h1fff, 14'h3fff},
        '{14'h0001, 14'h2001, 14'h0001}};

    sar_adc_conversion_sequencer #(.RANGE(RANGE_BIPOLAR)) u_dut (.clock(clock), .resetn(resetn),
        .conversion_start_n(startN), .serial_clock(sclkB), .comparator_high(compB),
        .trial_level(trialB), .sampler_hold(holdB), .busy(busyB), .asleep(sleepB),
        .serial_result_out(dataB), .serial_result_oe_n(oeB));
    sar_adc_conversion_sequencer #(.RANGE(RANGE_UNIPOLAR)) u_uni (.clock(clock), .resetn(resetn),
        .conversion_start_n(startN), .serial_clock(sclkU), .comparator_high(compU),
        .trial_level(trialU), .sampler_hold(holdU), .busy(busyU), .asleep(sleepU),
        .serial_result_out(dataU), .serial_result_oe_n(oeU));
    host_model u_hostB (.busy(busyB), .analogCode(analogCode), .trial_level(trialB),
        .serial_result_out(dataB), .serial_result_oe_n(oeB), .comparator_high(compB),
        .serial_clock(sclkB), .frame(frameB));
    host_model u_hostU (.busy(busyU), .analogCode(analogCode), .trial_level(trialU),
        .serial_result_out(dataU), .serial_result_oe_n(oeU), .comparator_high(compU),
        .serial_clock(sclkU), .frame(frameU));

    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string msg);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h want %h", $time, msg, seen, want);
        end
    endtask : check

    task automatic wait_busy(input logic lvl, output int n);
        n = 0;
        while (busyB !== lvl && n < 2200) begin
            @(negedge clock);
            n++;
        end
    endtask : wait_busy

    task automatic read_both(input logic [13:0] bip, input logic [13:0] uni);
        u_hostB.read_frame(16);
        u_hostU.read_frame(16);
        check(frameB, {2'b00, bip}, "bipolar frame");
        check(frameU, {2'b00, uni}, "unipolar frame");
        check(16'({oeB, oeU}), 16'h0003, "pin released");
        repeat (60) @(negedge clock);
    endtask : read_both

    task automatic convert();
        repeat (70) @(negedge clock);
        @(negedge clock) startN = 1'b0;
        repeat (5) @(negedge clock);
        startN = 1'b1;
        check(16'({busyB, holdB, busyU, holdU, oeB, oeU}), 16'h003f, "hold, busy, released");
        wait_busy(1'b0, n1);
        check(16'(n1 + 5 <= CONV_FAST_CYC), 16'h0001, "fast time");
        check(16'({sleepB, holdB}), 16'h0000, "awake, tracking");
        repeat (70) @(negedge clock);
    endtask : convert

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial begin
        #400000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        resetn = 1'b0;
        startN = 1'b1;
        analogCode = 14'h0000;
        repeat (2) @(negedge clock);
        check(16'({busyB, sleepB, oeB, holdB}), 16'h0002, "reset state");
        resetn = 1'b1;
        repeat (3) @(negedge clock);
        foreach (rows[i]) begin
            analogCode = rows[i].analog;
            convert();
            read_both(rows[i].bip, rows[i].uni);
            $display("row %0d done", i);
        end
        // Extra clocks past the frame, then a cut frame; a start edge must release and realign
        u_hostB.read_frame(16);
        u_hostU.read_frame(16);
        analogCode = 14'h2aaa;
        convert();
        u_hostB.read_frame(5);
        u_hostU.read_frame(5);
        check(16'({oeB, oeU}), 16'h0000, "pin driven mid-frame");
        check(16'({frameB[15:11], frameU[15:11]}), 16'h0025, "cut frame bits");
        repeat (60) @(negedge clock);
        convert();
        read_both(14'h0aaa, 14'h2aaa);
        $display("shift reset test done");
        // Start held low at the end of conversion, then a short high pulse wakes it
        analogCode = 14'h1234;
        repeat (70) @(negedge clock);
        @(negedge clock) startN = 1'b0;
        repeat (5) @(negedge clock);
        wait_busy(1'b0, n1);
        repeat (2) @(negedge clock);
        check(16'({sleepB, sleepU}), 16'h0003, "asleep");
        repeat (20) @(negedge clock);
        startN = 1'b1;
        repeat (20) @(negedge clock);
        startN = 1'b0;
        wait_busy(1'b1, n1);
        check(16'({sleepB, holdB, sleepU, holdU}), 16'h000a, "waking, tracking");
        repeat (WAKE_CYC) @(negedge clock);
        check(16'({sleepB, holdB, busyB}), 16'h0003, "woken, holding");
        wait_busy(1'b0, n2);
        check(16'(20 + n1 + WAKE_CYC + n2 <= CONV_SLEEP_CYC), 16'h0001, "sleep time");
        repeat (2) @(negedge clock);
        check(16'({sleepB, sleepU}), 16'h0003, "asleep again");
        repeat (70) @(negedge clock);
        read_both(14'h3234, 14'h1234);
        $display("auto-sleep test done");
        // A long high pulse: the device wakes, waits awake, and holds only at the next fall
        analogCode = 14'h0f0f;
        startN = 1'b1;
        repeat (1300) @(negedge clock);
        check(16'({sleepB, busyB, sleepU, busyU}), 16'h0000, "awake idle");
        convert();
        read_both(14'h2f0f, 14'h0f0f);
        $display("long wake test done");
        // Reset in mid-conversion returns busy, hold, sleep and the pin enable to their idle levels
        @(negedge clock) startN = 1'b0;
        repeat (5) @(negedge clock);
        startN = 1'b1;
        repeat (100) @(negedge clock);
        analogCode = 14'h3c3c;
        resetn = 1'b0;
        repeat (2) @(negedge clock);
        check(16'({busyB, sleepB, oeB, holdB, busyU, holdU}), 16'h0008, "mid-run reset");
        resetn = 1'b1;
        repeat (3) @(negedge clock);
        convert();
        read_both(14'h1c3c, 14'h3c3c);
        $display("mid-run reset test done");
        report_and_stop();
    end
endmodule : test_sar_adc_conversion_sequencer
